// ===== shared/sensor_int_defines.vh
// Constants for the sensor interrupt and status unit.
// Assumes inclusion by bare name from the design file.
`ifndef SENSOR_INT_DEFINES_VH
`define SENSOR_INT_DEFINES_VH
`define NUM_SLOTS 12
`define SLOT_A_TO_H 8
`define STAT_BYTES 6
`define SEQ_WIDTH 4
`define SEQ_MAX 4'hF
`define LEVEL_VALUE_WIDTH 8
`define LEVEL_SHIFT_MAX 5'h18
`define DATA_WIDTH 32
`define FIFO_COUNT_WIDTH 10
`define SUM_LEV1_BIT 5
`define SUM_LEV0_BIT 4
`define TYPE_SIGNAL 1'b0
`define TYPE_DARK 1'b1
`define DIR_ABOVE 1'b1
`define DIR_BELOW 1'b0
`define PIN_SEL_INT_X 2'h0
`define PIN_SEL_INT_Y 2'h1
`define PIN_SEL_SEQ 2'h2
`define PIN_SEL_LOW 2'h3
`endif

// ===== hw/sensor_interrupt_status_unit.v
// Interrupt, status flag and packet status byte logic of a multi-slot sensor front end.
// Assumes host read/write strobes and slot data updates arrive as one-cycle pulses on clk.
`timescale 1ns/100ps
`include "sensor_int_defines.vh"

module sensor_interrupt_status_unit #(
   parameter NUM_SLOTS = `NUM_SLOTS,
   parameter DATA_WIDTH = `DATA_WIDTH,
   parameter FIFO_COUNT_WIDTH = `FIFO_COUNT_WIDTH
) (
   input wire clk,
   input wire rst,
   input wire [NUM_SLOTS-1:0] data_update,
   input wire [NUM_SLOTS*DATA_WIDTH-1:0] signal_ch1,
   input wire [NUM_SLOTS*DATA_WIDTH-1:0] signal_ch2,
   input wire [NUM_SLOTS*DATA_WIDTH-1:0] dark_ch1,
   input wire [NUM_SLOTS*DATA_WIDTH-1:0] dark_ch2,
   input wire [NUM_SLOTS-1:0] hold_regs,
   input wire [NUM_SLOTS-1:0] level0_source_type,
   input wire [NUM_SLOTS-1:0] level0_direction,
   input wire [NUM_SLOTS-1:0] level0_channel_pick,
   input wire [NUM_SLOTS*8-1:0] level0_base_value,
   input wire [NUM_SLOTS*5-1:0] level0_shift_amount,
   input wire [NUM_SLOTS-1:0] level1_source_type,
   input wire [NUM_SLOTS-1:0] level1_direction,
   input wire [NUM_SLOTS-1:0] level1_channel_pick,
   input wire [NUM_SLOTS*8-1:0] level1_base_value,
   input wire [NUM_SLOTS*5-1:0] level1_shift_amount,
   input wire [FIFO_COUNT_WIDTH-1:0] fifo_byte_count,
   input wire [FIFO_COUNT_WIDTH-1:0] fifo_fill_threshold,
   input wire fifo_overflow_event,
   input wire fifo_underflow_event,
   input wire fifo_read,
   input wire [NUM_SLOTS-1:0] data_reg_read,
   input wire [NUM_SLOTS-1:0] data_flag_autoclear,
   input wire fifo_flag_autoclear,
   input wire status_write,
   input wire [NUM_SLOTS-1:0] data_clear_bits,
   input wire [NUM_SLOTS-1:0] level0_clear_bits,
   input wire [NUM_SLOTS-1:0] level1_clear_bits,
   input wire [2:0] fifo_clear_bits,
   input wire [NUM_SLOTS-1:0] data_enable_x,
   input wire [NUM_SLOTS-1:0] data_enable_y,
   input wire [NUM_SLOTS-1:0] level0_enable_x,
   input wire [NUM_SLOTS-1:0] level0_enable_y,
   input wire [NUM_SLOTS-1:0] level1_enable_x,
   input wire [NUM_SLOTS-1:0] level1_enable_y,
   input wire [2:0] fifo_enable_x,
   input wire [2:0] fifo_enable_y,
   input wire sequence_done,
   input wire packet_done,
   input wire summary_byte_enable,
   input wire data_low_byte_enable,
   input wire data_high_byte_enable,
   input wire level0_byte_enable,
   input wire level1_byte_enable,
   input wire level_upper_byte_enable,
   input wire status_byte_ready,
   input wire [1:0] pin0_select,
   input wire [1:0] pin1_select,
   input wire [1:0] pin0_seq_bit,
   input wire [1:0] pin1_seq_bit,
   output reg [NUM_SLOTS-1:0] data_flags_reg,
   output reg [NUM_SLOTS-1:0] slot_level0_flag,
   output reg [NUM_SLOTS-1:0] slot_level1_flag,
   output reg fifo_fill_flag,
   output reg fifo_overflow_flag,
   output reg fifo_underflow_flag,
   output reg [`SEQ_WIDTH-1:0] sequence_count_reg,
   output wire int_x,
   output wire int_y,
   output reg [1:0] general_pin,
   output wire status_byte_valid,
   output reg [7:0] status_byte_data,
   output wire status_busy
);

   reg [`STAT_BYTES-1:0] pending_reg;
   reg [`STAT_BYTES-1:0] pending_next;
   reg [NUM_SLOTS-1:0] data_flags_next;
   reg [NUM_SLOTS-1:0] level0_flags_next;
   reg [NUM_SLOTS-1:0] level1_flags_next;
   reg fill_next;
   reg overflow_next;
   reg underflow_next;
   reg [2:0] fifo_set;
   reg [2:0] fifo_auto_clr;
   reg [2:0] fifo_flags;
   reg [7:0] byte_sel;
   reg [2:0] byte_idx;
   reg [`SEQ_WIDTH-1:0] seq_next;
   wire [NUM_SLOTS-1:0] lev0_hit;
   wire [NUM_SLOTS-1:0] lev1_hit;
   wire [NUM_SLOTS-1:0] data_clr;
   wire [NUM_SLOTS-1:0] lev0_clr;
   wire [NUM_SLOTS-1:0] lev1_clr;
   wire [3*NUM_SLOTS+2:0] all_flags;
   wire [3*NUM_SLOTS+2:0] all_en_x;
   wire [3*NUM_SLOTS+2:0] all_en_y;
   wire [`SLOT_A_TO_H-1:0] lev0_low;
   wire [`SLOT_A_TO_H-1:0] lev1_low;
   wire [7:0] byte_sum;
   wire [7:0] byte_d1;
   wire [7:0] byte_d2;
   wire [7:0] byte_lx;
   wire [`STAT_BYTES-1:0] byte_en;
   wire [`STAT_BYTES-1:0] first_pending;
   wire [`STAT_BYTES-1:0] next_first;
   wire [1:0] pin_next;
   wire fill_over;
   wire fill_under;
   wire fill_clr;
   wire overflow_clr;
   wire underflow_clr;
   wire byte_pop;
   wire any_lev0;
   wire any_lev1;
   integer i;

   // Comparators per slot; hold settings are never consulted here.
   genvar s;
   generate
      for (s = 0; s < NUM_SLOTS; s = s + 1) begin : slot_cmp
         wire [DATA_WIDTH-1:0] sig1;
         wire [DATA_WIDTH-1:0] sig2;
         wire [DATA_WIDTH-1:0] drk1;
         wire [DATA_WIDTH-1:0] drk2;
         wire [DATA_WIDTH-1:0] src0;
         wire [DATA_WIDTH-1:0] src1;
         wire [DATA_WIDTH-1:0] thr0;
         wire [DATA_WIDTH-1:0] thr1;
         wire [4:0] sh0;
         wire [4:0] sh1;
         wire above0;
         wire below0;
         wire above1;
         wire below1;
         assign sig1 = signal_ch1[s*DATA_WIDTH+:DATA_WIDTH];
         assign sig2 = signal_ch2[s*DATA_WIDTH+:DATA_WIDTH];
         assign drk1 = dark_ch1[s*DATA_WIDTH+:DATA_WIDTH];
         assign drk2 = dark_ch2[s*DATA_WIDTH+:DATA_WIDTH];
         // Shift amounts above the maximum saturate at the maximum.
         assign sh0 = (level0_shift_amount[s*5+:5] > `LEVEL_SHIFT_MAX) ? `LEVEL_SHIFT_MAX : level0_shift_amount[s*5+:5];
         assign sh1 = (level1_shift_amount[s*5+:5] > `LEVEL_SHIFT_MAX) ? `LEVEL_SHIFT_MAX : level1_shift_amount[s*5+:5];
         assign thr0 = {{(DATA_WIDTH-8){1'b0}}, level0_base_value[s*8+:8]} << sh0;
         assign thr1 = {{(DATA_WIDTH-8){1'b0}}, level1_base_value[s*8+:8]} << sh1;
         // Source register picked by type and channel.
         assign src0 = (level0_source_type[s] == `TYPE_DARK) ? (level0_channel_pick[s] ? drk2 : drk1) :
            (level0_channel_pick[s] ? sig2 : sig1);
         assign src1 = (level1_source_type[s] == `TYPE_DARK) ? (level1_channel_pick[s] ? drk2 : drk1) :
            (level1_channel_pick[s] ? sig2 : sig1);
         assign above0 = src0 > thr0;
         assign below0 = src0 < thr0;
         assign above1 = src1 > thr1;
         assign below1 = src1 < thr1;
         // Comparison is made only on a data update; both directions are strict.
         assign lev0_hit[s] = data_update[s] & ((level0_direction[s] == `DIR_ABOVE) ? above0 : below0);
         assign lev1_hit[s] = data_update[s] & ((level1_direction[s] == `DIR_ABOVE) ? above1 : below1);
      end
   endgenerate

   // Write-one clears and auto-clear on data register reads.
   assign data_clr = (status_write ? data_clear_bits : {NUM_SLOTS{1'b0}}) | (data_reg_read & data_flag_autoclear);
   assign lev0_clr = status_write ? level0_clear_bits : {NUM_SLOTS{1'b0}};
   assign lev1_clr = status_write ? level1_clear_bits : {NUM_SLOTS{1'b0}};

   always @* begin
      fifo_set = {fifo_underflow_event, fifo_overflow_event, 1'b0};
      fifo_auto_clr = (fifo_read & fifo_flag_autoclear) ? 3'h7 : 3'h0;
      fifo_flags = {fifo_underflow_flag, fifo_overflow_flag, fifo_fill_flag};
   end

   // FIFO flag clears come from a written one or an enabled clear on read; the fill flag also clears on any read below threshold.
   assign fill_over = fifo_byte_count > fifo_fill_threshold;
   assign fill_under = fifo_byte_count < fifo_fill_threshold;
   assign fill_clr = (status_write & fifo_clear_bits[0]) | fifo_auto_clr[0];
   assign overflow_clr = (status_write & fifo_clear_bits[1]) | fifo_auto_clr[1];
   assign underflow_clr = (status_write & fifo_clear_bits[2]) | fifo_auto_clr[2];

   // Set beats clear; flags hold otherwise and ignore enables.
   always @* begin
      data_flags_next = (data_flags_reg & ~data_clr) | data_update;
      level0_flags_next = (slot_level0_flag & ~lev0_clr) | lev0_hit;
      level1_flags_next = (slot_level1_flag & ~lev1_clr) | lev1_hit;
      overflow_next = (fifo_flags[1] & ~overflow_clr) | fifo_set[1];
      underflow_next = (fifo_flags[2] & ~underflow_clr) | fifo_set[2];
      fill_next = fifo_fill_flag;
      if (fill_over)
         fill_next = 1'b1;
      else if (fifo_read && fill_under)
         fill_next = 1'b0;
      else if (fill_clr)
         fill_next = 1'b0;
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         data_flags_reg <= {NUM_SLOTS{1'b0}};
         slot_level0_flag <= {NUM_SLOTS{1'b0}};
         slot_level1_flag <= {NUM_SLOTS{1'b0}};
      end else begin
         data_flags_reg <= data_flags_next;
         slot_level0_flag <= level0_flags_next;
         slot_level1_flag <= level1_flags_next;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_fill_flag <= 1'b0;
         fifo_overflow_flag <= 1'b0;
         fifo_underflow_flag <= 1'b0;
      end else begin
         fifo_fill_flag <= fill_next;
         fifo_overflow_flag <= overflow_next;
         fifo_underflow_flag <= underflow_next;
      end
   end

   // Sequence counter wraps naturally from 15 to 0.
   always @* begin
      seq_next = sequence_count_reg;
      if (sequence_done)
         seq_next = (sequence_count_reg == `SEQ_MAX) ? {`SEQ_WIDTH{1'b0}} : sequence_count_reg + 4'h1;
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         sequence_count_reg <= {`SEQ_WIDTH{1'b0}};
      else
         sequence_count_reg <= seq_next;
   end

   // Interrupt outputs as OR of enabled flags.
   assign all_flags = {fifo_flags, slot_level1_flag, slot_level0_flag, data_flags_reg};
   assign all_en_x = {fifo_enable_x, level1_enable_x, level0_enable_x, data_enable_x};
   assign all_en_y = {fifo_enable_y, level1_enable_y, level0_enable_y, data_enable_y};
   assign int_x = |(all_flags & all_en_x);
   assign int_y = |(all_flags & all_en_y);

   // Pin routing of interrupts or sequence bits, one mux per general pin.
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : pin_mux
         wire [1:0] sel;
         wire [1:0] seq_bit;
         reg val;
         assign sel = (p == 0) ? pin0_select : pin1_select;
         assign seq_bit = (p == 0) ? pin0_seq_bit : pin1_seq_bit;
         always @* begin
            case (sel)
               `PIN_SEL_INT_X: val = int_x;
               `PIN_SEL_INT_Y: val = int_y;
               `PIN_SEL_SEQ: val = sequence_count_reg[seq_bit];
               default: val = 1'b0;
            endcase
         end
         assign pin_next[p] = val;
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst)
         general_pin <= 2'h0;
      else
         general_pin <= pin_next;
   end

   // Status byte contents.
   assign any_lev0 = |slot_level0_flag;
   assign any_lev1 = |slot_level1_flag;
   assign byte_sum = {2'b00, any_lev1, any_lev0, sequence_count_reg};
   assign byte_d1 = data_flags_reg[`SLOT_A_TO_H-1:0];
   assign byte_d2 = {{(16-NUM_SLOTS){1'b0}}, data_flags_reg[NUM_SLOTS-1:`SLOT_A_TO_H]};
   assign lev0_low = slot_level0_flag[`SLOT_A_TO_H-1:0];
   assign lev1_low = slot_level1_flag[`SLOT_A_TO_H-1:0];
   assign byte_lx = {slot_level1_flag[NUM_SLOTS-1:`SLOT_A_TO_H], slot_level0_flag[NUM_SLOTS-1:`SLOT_A_TO_H]};
   assign byte_en = {level_upper_byte_enable, level1_byte_enable, level0_byte_enable,
      data_high_byte_enable, data_low_byte_enable, summary_byte_enable};

   // Lowest pending byte goes first, giving the fixed order.
   assign first_pending = pending_reg & (~pending_reg + 6'h01);
   assign next_first = pending_next & (~pending_next + 6'h01);
   assign status_byte_valid = |pending_reg;
   assign status_busy = |pending_reg;
   assign byte_pop = status_byte_valid & status_byte_ready;

   // A pop retires the offered byte; an idle unit loads the enabled set at packet end.
   always @* begin
      pending_next = pending_reg;
      if (byte_pop)
         pending_next = pending_reg & ~first_pending;
      if (packet_done && !status_byte_valid)
         pending_next = byte_en;
   end

   // The data register takes the byte that leads next cycle, so it always matches valid.
   always @* begin
      byte_idx = 3'h0;
      for (i = 0; i < `STAT_BYTES; i = i + 1) begin
         if (next_first[i])
            byte_idx = i[2:0];
      end
      case (byte_idx)
         3'h0: byte_sel = byte_sum;
         3'h1: byte_sel = byte_d1;
         3'h2: byte_sel = byte_d2;
         3'h3: byte_sel = lev0_low;
         3'h4: byte_sel = lev1_low;
         3'h5: byte_sel = byte_lx;
         default: byte_sel = 8'h00;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         pending_reg <= {`STAT_BYTES{1'b0}};
      else
         pending_reg <= pending_next;
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         status_byte_data <= 8'h00;
      else
         status_byte_data <= byte_sel;
   end

endmodule

// ===== test/status_unit_checker_assertions.sv
// Concurrent checks on the ports of the sensor interrupt and status unit.
// Assumes one clock, clk, and an asynchronous active-high reset, rst.
`timescale 1ns/100ps
module status_unit_checker #(
   parameter NUM_SLOTS = 12
) (
   input wire clk, rst, status_write, sequence_done, fifo_overflow_event,
   input wire [NUM_SLOTS-1:0] data_update, data_flags_reg, slot_level0_flag, slot_level1_flag,
   input wire [NUM_SLOTS-1:0] data_enable_x, data_enable_y, level0_enable_x, level0_enable_y, level1_enable_x,
   input wire [NUM_SLOTS-1:0] level1_enable_y, data_clear_bits, data_reg_read, data_flag_autoclear,
   input wire fifo_fill_flag, fifo_overflow_flag, fifo_underflow_flag, int_x, int_y,
   input wire [2:0] fifo_enable_x, fifo_enable_y,
   input wire [9:0] fifo_byte_count, fifo_fill_threshold,
   input wire [3:0] sequence_count_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire [2:0] fifo_flags = {fifo_underflow_flag, fifo_overflow_flag, fifo_fill_flag};
   wire x_exp = |(data_flags_reg & data_enable_x) | |(slot_level0_flag & level0_enable_x) |
      |(slot_level1_flag & level1_enable_x) | |(fifo_flags & fifo_enable_x);
   wire y_exp = |(data_flags_reg & data_enable_y) | |(slot_level0_flag & level0_enable_y) |
      |(slot_level1_flag & level1_enable_y) | |(fifo_flags & fifo_enable_y);
   a_int_x_or: assert property (int_x == x_exp) else $error("int_x differs from enabled flags");
   a_int_y_or: assert property (int_y == y_exp) else $error("int_y differs from enabled flags");
   a_data_set: assert property ((data_update != 0) |=>
      ((data_flags_reg & $past(data_update)) == $past(data_update))) else $error("data flag not set");
   a_flag_hold: assert property ((!status_write && (data_reg_read & data_flag_autoclear) == 0) |=>
      ((data_flags_reg & $past(data_flags_reg)) == $past(data_flags_reg))) else $error("data flag lost");
   a_write_clear: assert property ((status_write && data_update == 0) |=>
      ((data_flags_reg & $past(data_clear_bits)) == 0)) else $error("data flag not cleared");
   a_fill_set: assert property ((fifo_byte_count > fifo_fill_threshold) |=> fifo_fill_flag)
      else $error("fill flag not set");
   a_ovf_set: assert property (fifo_overflow_event |=> fifo_overflow_flag)
      else $error("overflow flag not set");
   a_seq_step: assert property (sequence_done |=>
      (sequence_count_reg == 4'($past(sequence_count_reg) + 4'h1))) else $error("sequence step wrong");
   a_seq_still: assert property (!sequence_done |=> $stable(sequence_count_reg))
      else $error("sequence moved without cause");
endmodule
bind sensor_interrupt_status_unit status_unit_checker #(.NUM_SLOTS(NUM_SLOTS)) u_chk (.*);

// ===== test/host_model.sv
// Host model that drains the appended status bytes of the sensor unit.
// Assumes the byte handshake runs on clk, with rst active high.
`timescale 1ns/100ps
module host_model (
   input wire clk,
   input wire rst,
   input wire hold_off,
   input wire status_byte_valid,
   input wire [7:0] status_byte_data,
   output logic status_byte_ready
);
   logic [7:0] got [$];
   // Ready rises the cycle after valid and drops after each take, so bytes arrive every other cycle.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         status_byte_ready <= 1'b0;
      end else begin
         if (status_byte_valid && status_byte_ready) begin
            got.push_back(status_byte_data);
         end
         status_byte_ready <= status_byte_valid && !status_byte_ready && !hold_off;
      end
   end
endmodule

// ===== test/tb.sv
// Self-checking bench for the sensor interrupt and status unit.
// Assumes the unit, its checker and the host model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
   logic clk = 0, rst = 1, hold_off = 0;
   int mismatches = 0, num_checks = 0;
   logic [11:0] data_update = '0, hold_regs = '0, level0_source_type = '0, level0_direction = '0,
      level0_channel_pick = '0, level1_source_type = '0, level1_direction = '0, level1_channel_pick = '0,
      data_reg_read = '0, data_flag_autoclear = '0, data_clear_bits = '0, level0_clear_bits = '0,
      level1_clear_bits = '0, data_enable_x = '0, data_enable_y = '0, level0_enable_x = 12'h002,
      level0_enable_y = '0, level1_enable_x = '0, level1_enable_y = 12'h001;
   logic [383:0] signal_ch1 = '0, signal_ch2 = '0, dark_ch1 = '0, dark_ch2 = '0;
   logic [95:0] level0_base_value = '0, level1_base_value = '0;
   logic [59:0] level0_shift_amount = '0, level1_shift_amount = '0;
   logic [9:0] fifo_byte_count = '0, fifo_fill_threshold = '0;
   logic [2:0] fifo_clear_bits = '0, fifo_enable_x = 3'b100, fifo_enable_y = '0;
   logic [1:0] pin0_select = '0, pin1_select = '0, pin0_seq_bit = '0, pin1_seq_bit = '0;
   logic fifo_overflow_event = 0, fifo_underflow_event = 0, fifo_read = 0, fifo_flag_autoclear = 0;
   logic status_write = 0, sequence_done = 0, packet_done = 0, summary_byte_enable = 0, data_low_byte_enable = 0;
   logic data_high_byte_enable = 0, level0_byte_enable = 0, level1_byte_enable = 0, level_upper_byte_enable = 0;
   logic [11:0] data_flags_reg, slot_level0_flag, slot_level1_flag;
   logic [7:0] status_byte_data;
   logic [3:0] sequence_count_reg;
   logic [1:0] general_pin;
   logic fifo_fill_flag, fifo_overflow_flag, fifo_underflow_flag, int_x, int_y;
   logic status_byte_valid, status_busy, status_byte_ready;
   logic [7:0] exp_bytes [6] = '{8'h21, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00};
   sensor_interrupt_status_unit u_dut (.*);
   host_model u_host (.clk(clk), .rst(rst), .hold_off(hold_off), .status_byte_valid(status_byte_valid),
      .status_byte_data(status_byte_data), .status_byte_ready(status_byte_ready));
   initial forever #5 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Programs slot A comparators, updates slot A data and checks both level flags.
   task automatic level_case(input logic [1:0] k, input logic [7:0] b, input logic [4:0] sh,
      input logic [31:0] val, input logic d0, input logic [1:0] e);
      logic [127:0] v;
      v = {4{d0 ? 32'h0 : 32'hFFFFFFFF}};
      v[(3 - k) * 32 +: 32] = val;
      tick(1);
      {signal_ch1[31:0], signal_ch2[31:0], dark_ch1[31:0], dark_ch2[31:0]} <= v;
      {level0_source_type[0], level0_channel_pick[0], level1_source_type[0], level1_channel_pick[0]} <= {k, k};
      {level0_direction[0], level1_direction[0]} <= {d0, ~d0};
      {level0_base_value[7:0], level1_base_value[7:0], level0_shift_amount[4:0]} <= {b, b, sh};
      {level1_shift_amount[4:0], status_write, level0_clear_bits, level1_clear_bits} <= {sh, 1'b1, 24'hFFFFFF};
      tick(1);
      {status_write, data_update} <= {1'b0, 12'h001};
      tick(1);
      data_update <= '0;
      #1 `CHK("levels", e, {slot_level1_flag[0], slot_level0_flag[0]})
   endtask
   initial begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      {hold_regs, data_enable_x, pin1_select, data_update} <= {12'hFFF, 12'h008, 2'h1, 12'h808};
      tick(1);
      data_update <= '0;
      #1 `CHK("data flags", 12'h808, data_flags_reg)
      `CHK("int x", 1'b1, int_x)
      tick(1);
      #1 `CHK("pins", 2'b01, general_pin)
      tick(1);
      {status_write, data_clear_bits, data_update} <= {1'b1, 12'h808, 12'h800};
      tick(1);
      {status_write, data_update} <= '0;
      #1 `CHK("write clear", 12'h800, data_flags_reg)
      tick(1);
      {data_flag_autoclear, data_reg_read} <= {12'h800, 12'h800};
      tick(1);
      data_reg_read <= '0;
      #1 `CHK("read clear", 12'h000, data_flags_reg)
      for (int k = 0; k < 4; k++) level_case(k[1:0], 8'h10, 5'h04, 32'h101, 1'b1, 2'b01);
      level_case(2'h0, 8'h10, 5'h04, 32'h100, 1'b1, 2'b00);
      level_case(2'h3, 8'h01, 5'h18, 32'h00FFFFFF, 1'b0, 2'b01);
      level_case(2'h1, 8'h01, 5'h18, 32'h01000001, 1'b0, 2'b10);
      `CHK("level int y", 1'b1, int_y)
      tick(1);
      {fifo_fill_threshold, fifo_byte_count, fifo_enable_y} <= {10'h004, 10'h005, 3'b010};
      tick(2);
      #1 `CHK("fill set", 1'b1, fifo_fill_flag)
      tick(1);
      {fifo_byte_count, fifo_read} <= {10'h004, 1'b1};
      tick(1);
      {fifo_byte_count, fifo_read} <= {10'h003, 1'b1};
      #1 `CHK("fill kept", 1'b1, fifo_fill_flag)
      tick(1);
      {fifo_read, fifo_overflow_event} <= 2'b01;
      tick(1);
      fifo_overflow_event <= 1'b0;
      #1 `CHK("fifo flags", 3'b010, {fifo_underflow_flag, fifo_overflow_flag, fifo_fill_flag})
      `CHK("oflow ints", 2'b10, {int_y, int_x})
      tick(1);
      {fifo_flag_autoclear, fifo_underflow_event} <= 2'b11;
      tick(1);
      {fifo_underflow_event, fifo_read} <= 2'b01;
      #1 `CHK("uflow int x", 1'b1, int_x)
      tick(1);
      fifo_read <= 1'b0;
      #1 `CHK("fifo read clear", 3'b000, {fifo_underflow_flag, fifo_overflow_flag, fifo_fill_flag})
      tick(1);
      {sequence_done, pin0_select, pin0_seq_bit} <= {1'b1, 2'h2, 2'h0};
      tick(17);
      sequence_done <= 1'b0;
      #1 `CHK("sequence", 4'h1, sequence_count_reg)
      tick(1);
      #1 `CHK("sequence pin", 1'b1, general_pin[0])
      tick(1);
      data_update <= 12'h201;
      tick(1);
      {data_update, summary_byte_enable, data_low_byte_enable, data_high_byte_enable} <= {12'h000, 3'b111};
      {level0_byte_enable, level1_byte_enable, level_upper_byte_enable, packet_done, hold_off} <= 5'h1F;
      tick(1);
      packet_done <= 1'b0;
      tick(8);
      #1 `CHK("valid stands", 1'b1, status_byte_valid)
      `CHK("busy stands", 1'b1, status_busy)
      tick(1);
      hold_off <= 1'b0;
      tick(30);
      `CHK("byte count", 6, u_host.got.size())
      for (int i = 0; i < 6; i++) `CHK("status byte", exp_bytes[i], u_host.got[i])
      `CHK("drained", 1'b0, status_busy)
      {summary_byte_enable, data_low_byte_enable, level0_byte_enable, level_upper_byte_enable, packet_done} <= 5'h01;
      tick(1);
      packet_done <= 1'b0;
      tick(12);
      `CHK("byte count two", 8, u_host.got.size())
      `CHK("enabled bytes", 16'h0201, {u_host.got[6], u_host.got[7]})
      tally_and_finish();
   end
   initial begin
      tick(5000);
      mismatches++;
      tally_and_finish();
   end
endmodule
